// File: src/mcs_pkg.sv
// Package: cycle types, status bit positions, status patterns, carriers
package mcs_pkg;

  // Status bit positions on the data bus
  localparam int IRQ_ACK_BIT = 0;
  localparam int WRITE_NOT_BIT = 1;
  localparam int STACK_BIT = 2;
  localparam int HALT_ACK_BIT = 3;
  localparam int PORT_OUT_BIT = 4;
  localparam int OPCODE_FETCH_BIT = 5;
  localparam int PORT_INPUT_BIT = 6;
  localparam int MEM_READ_BIT = 7;

  // Status byte patterns, one per cycle type
  localparam logic [7:0] ST_FETCH = 8'ha2;
  localparam logic [7:0] ST_MEM_RD = 8'h82;
  localparam logic [7:0] ST_STACK_RD = 8'h86;
  localparam logic [7:0] ST_PORT_IN = 8'h42;
  localparam logic [7:0] ST_IRQ_ACK = 8'h23;
  localparam logic [7:0] ST_HALT_ACK = 8'h8a;
  localparam logic [7:0] ST_HALT_IRQ_ACK = 8'h2b;
  localparam logic [7:0] ST_MEM_WR = 8'h00;
  localparam logic [7:0] ST_STACK_WR = 8'h04;
  localparam logic [7:0] ST_PORT_OUT = 8'h10;

  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;

  // Machine cycle types
  typedef enum logic [3:0] {
    CYC_FETCH = 4'h0,
    CYC_MEM_RD = 4'h1,
    CYC_STACK_RD = 4'h2,
    CYC_PORT_IN = 4'h3,
    CYC_IRQ_ACK = 4'h4,
    CYC_HALT_ACK = 4'h5,
    CYC_HALT_IRQ_ACK = 4'h6,
    CYC_MEM_WR = 4'h7,
    CYC_STACK_WR = 4'h8,
    CYC_PORT_OUT = 4'h9
  } cycle_e;

  // Machine cycle states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_T1 = 3'h1,
    ST_T2 = 3'h2,
    ST_TW = 3'h3,
    ST_T3 = 3'h4,
    ST_T4 = 3'h5,
    ST_T5 = 3'h6,
    ST_TH = 3'h7
  } tstate_e;

  // Cycle request from the sequencer
  typedef struct packed {
    cycle_e kind;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic need_t4;
    logic need_t5;
  } cycle_req_s;

  // Bus pins driven by the block
  typedef struct packed {
    logic [15:0] addr;
    logic addr_oe;
    logic [7:0] data_o;
    logic data_oe;
    logic cycle_sync;
    logic data_in_en;
    logic write_n;
    logic wait_o;
    logic hold_ack;
  } bus_out_s;

  // Whole module state
  typedef struct packed {
    tstate_e st;
    cycle_req_s cur;
    logic [7:0] status;
    logic [7:0] rdata;
    logic rdata_valid;
    logic hold_pend;
    logic ready_s1;
    logic ready_s2;
    logic hold_s1;
    logic hold_s2;
  } state_s;

endpackage

// File: src/machine_cycle_status_word.sv
// Machine cycle sequencer that emits the status byte at each cycle start
`timescale 1ns/1ps

// Overview of operation
// - In T1 drive the 8-bit status byte on data lines while strobe high
// - Bit 0 high in interrupt acknowledge cycles only
// - Bit 1 high for read cycles, low for memory or port writes
// - Bit 2 high when the address comes from the stack pointer
// - Bit 3 high while halt instruction runs and device stays halted
// - Bit 4 high when address carries output port and data the value
// - Port cycles put the port number on both address halves
// - Bit 5 high only in first-byte fetch and interrupt acknowledge cycles
// - Bit 6 high when address carries input port and data is received
// - Bit 7 high whenever data bus carries memory read data
// - Hold state entered after a machine cycle while hold stays requested
// - Wait, T4 and T5 are inserted only when the cycle needs them
// - Ready level decides how many wait states are inserted
// - Read patterns: fetch A2, mem 82, stack 86, input 42, halt 8A
// - Interrupt ack 23, halted interrupt ack 2B, bit 0 clear otherwise
// - Writes clear bit 1: memory 00, stack 04, port output 10
// - Cycle-start strobe only at the start of each machine cycle
// - Ready low in T2 enters wait and raises wait; ready high goes T3
module machine_cycle_status_word (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic phase_en,
  input wire logic req_valid,
  output logic req_ready,
  input wire mcs_pkg::cycle_req_s req,
  input wire logic ready_in,
  input wire logic hold_req,
  input wire logic [7:0] data_i,
  output mcs_pkg::bus_out_s bus,
  output logic [7:0] rd_data,
  output logic rd_valid
);

  // ----------------------------------------------------------------
  // Status decode
  // ----------------------------------------------------------------

  // Map a cycle type to its status byte
  function automatic logic [7:0] status_of(input mcs_pkg::cycle_e k);
    logic [7:0] s;
    s = mcs_pkg::STATUS_RST;
    unique case (k)
      mcs_pkg::CYC_FETCH: s = mcs_pkg::ST_FETCH;
      mcs_pkg::CYC_MEM_RD: s = mcs_pkg::ST_MEM_RD;
      mcs_pkg::CYC_STACK_RD: s = mcs_pkg::ST_STACK_RD;
      mcs_pkg::CYC_PORT_IN: s = mcs_pkg::ST_PORT_IN;
      mcs_pkg::CYC_IRQ_ACK: s = mcs_pkg::ST_IRQ_ACK;
      mcs_pkg::CYC_HALT_ACK: s = mcs_pkg::ST_HALT_ACK;
      mcs_pkg::CYC_HALT_IRQ_ACK: s = mcs_pkg::ST_HALT_IRQ_ACK;
      mcs_pkg::CYC_MEM_WR: s = mcs_pkg::ST_MEM_WR;
      mcs_pkg::CYC_STACK_WR: s = mcs_pkg::ST_STACK_WR;
      mcs_pkg::CYC_PORT_OUT: s = mcs_pkg::ST_PORT_OUT;
      default: s = mcs_pkg::STATUS_RST;
    endcase
    return s;
  endfunction

  // Write cycles drive data from T2 through T3
  function automatic logic is_write(input mcs_pkg::cycle_e k);
    return k == mcs_pkg::CYC_MEM_WR || k == mcs_pkg::CYC_STACK_WR ||
      k == mcs_pkg::CYC_PORT_OUT;
  endfunction

  // Halt acknowledge cycles keep no data transfer
  function automatic logic is_halt(input mcs_pkg::cycle_e k);
    return k == mcs_pkg::CYC_HALT_ACK;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  mcs_pkg::state_s q_ff;
  mcs_pkg::state_s nxt_q;
  logic start_ok;
  logic [15:0] port_addr;

  // A new cycle starts only from idle or hold, with no hold request seen;
  // this must match the idle/hold branch below or a request is lost
  assign start_ok = req_valid && phase_en && !q_ff.hold_s2 &&
    (q_ff.st == mcs_pkg::ST_IDLE || q_ff.st == mcs_pkg::ST_TH);
  assign req_ready = start_ok;

  // Port number repeated on both address halves
  assign port_addr = {req.addr[7:0], req.addr[7:0]};

  // Next state
  always_comb begin
    nxt_q = q_ff;
    nxt_q.ready_s1 = ready_in;
    nxt_q.ready_s2 = q_ff.ready_s1;
    nxt_q.hold_s1 = hold_req;
    nxt_q.hold_s2 = q_ff.hold_s1;
    nxt_q.rdata_valid = 1'b0;
    if (phase_en) begin
      unique case (q_ff.st)
        mcs_pkg::ST_IDLE, mcs_pkg::ST_TH: begin
          if (q_ff.hold_s2) begin
            nxt_q.st = mcs_pkg::ST_TH;
          end else if (req_valid) begin
            nxt_q.st = mcs_pkg::ST_T1;
            nxt_q.cur = req;
            // Port cycles replicate the port number
            if (req.kind == mcs_pkg::CYC_PORT_IN ||
                req.kind == mcs_pkg::CYC_PORT_OUT) begin
              nxt_q.cur.addr = port_addr;
            end
            nxt_q.status = status_of(req.kind);
          end else begin
            nxt_q.st = mcs_pkg::ST_IDLE;
          end
          nxt_q.hold_pend = 1'b0;
        end
        mcs_pkg::ST_T1: nxt_q.st = mcs_pkg::ST_T2;
        mcs_pkg::ST_T2, mcs_pkg::ST_TW: begin
          // Ready low holds the cycle in wait
          if (q_ff.ready_s2) begin
            nxt_q.st = mcs_pkg::ST_T3;
            nxt_q.hold_pend = q_ff.hold_s2;
          end else begin
            nxt_q.st = mcs_pkg::ST_TW;
          end
        end
        mcs_pkg::ST_T3: begin
          // Capture only when the data bus was turned inward
          if (!is_write(q_ff.cur.kind) && !is_halt(q_ff.cur.kind)) begin
            nxt_q.rdata = data_i;
            nxt_q.rdata_valid = 1'b1;
          end
          if (q_ff.cur.need_t4) begin
            nxt_q.st = mcs_pkg::ST_T4;
          end else begin
            nxt_q.st = q_ff.hold_pend ? mcs_pkg::ST_TH : mcs_pkg::ST_IDLE;
          end
        end
        mcs_pkg::ST_T4: begin
          if (q_ff.cur.need_t5) begin
            nxt_q.st = mcs_pkg::ST_T5;
          end else begin
            nxt_q.st = q_ff.hold_pend ? mcs_pkg::ST_TH : mcs_pkg::ST_IDLE;
          end
        end
        mcs_pkg::ST_T5: begin
          nxt_q.st = q_ff.hold_pend ? mcs_pkg::ST_TH : mcs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Register the state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------

  // Data bus carries status only in T1, write data in T2..T3
  always_comb begin
    bus = '0;
    bus.addr = q_ff.cur.addr;
    bus.addr_oe = q_ff.st inside {mcs_pkg::ST_T1, mcs_pkg::ST_T2,
      mcs_pkg::ST_TW, mcs_pkg::ST_T3};
    bus.cycle_sync = q_ff.st == mcs_pkg::ST_T1;
    bus.hold_ack = q_ff.st == mcs_pkg::ST_TH;
    bus.wait_o = q_ff.st == mcs_pkg::ST_TW;
    if (q_ff.st == mcs_pkg::ST_T1) begin
      bus.data_o = q_ff.status;
      bus.data_oe = 1'b1;
    end else if (is_write(q_ff.cur.kind) && (q_ff.st == mcs_pkg::ST_T2 ||
        q_ff.st == mcs_pkg::ST_TW || q_ff.st == mcs_pkg::ST_T3)) begin
      bus.data_o = q_ff.cur.wdata;
      bus.data_oe = 1'b1;
    end
    bus.write_n = !(is_write(q_ff.cur.kind) &&
      (q_ff.st == mcs_pkg::ST_TW || q_ff.st == mcs_pkg::ST_T3));
    bus.data_in_en = !is_write(q_ff.cur.kind) &&
      !is_halt(q_ff.cur.kind) && (q_ff.st == mcs_pkg::ST_T2 ||
      q_ff.st == mcs_pkg::ST_TW || q_ff.st == mcs_pkg::ST_T3);
  end

  assign rd_data = q_ff.rdata;
  assign rd_valid = q_ff.rdata_valid;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  property p_status_in_t1;
    @(posedge clk) disable iff (!arst_n)
    bus.cycle_sync |-> bus.data_oe && bus.data_o == q_ff.status;
  endproperty
  a_status_in_t1: assert property (p_status_in_t1)
    else $error("status not driven during cycle start");

  property p_irq_bit;
    @(posedge clk) disable iff (!arst_n)
    bus.cycle_sync |-> bus.data_o[mcs_pkg::IRQ_ACK_BIT] ==
      (q_ff.cur.kind inside {mcs_pkg::CYC_IRQ_ACK,
       mcs_pkg::CYC_HALT_IRQ_ACK});
  endproperty
  a_irq_bit: assert property (p_irq_bit)
    else $error("interrupt bit wrong");

  property p_write_bit;
    @(posedge clk) disable iff (!arst_n)
    bus.cycle_sync |-> bus.data_o[mcs_pkg::WRITE_NOT_BIT] ==
      !is_write(q_ff.cur.kind);
  endproperty
  a_write_bit: assert property (p_write_bit)
    else $error("write bit wrong");

  property p_port_addr;
    @(posedge clk) disable iff (!arst_n)
    bus.cycle_sync && q_ff.cur.kind inside {mcs_pkg::CYC_PORT_IN,
      mcs_pkg::CYC_PORT_OUT} |-> bus.addr[15:8] == bus.addr[7:0];
  endproperty
  a_port_addr: assert property (p_port_addr)
    else $error("port number not on both halves");

  property p_sync_one;
    @(posedge clk) disable iff (!arst_n)
    $rose(bus.cycle_sync) && phase_en |=> !bus.cycle_sync;
  endproperty
  a_sync_one: assert property (p_sync_one)
    else $error("cycle start held too long");

  property p_stable;
    @(posedge clk) disable iff (!arst_n)
    bus.cycle_sync && $past(bus.cycle_sync) |-> $stable(bus.data_o);
  endproperty
  a_stable: assert property (p_stable)
    else $error("status changed during cycle start");

  property p_wait;
    @(posedge clk) disable iff (!arst_n)
    q_ff.st == mcs_pkg::ST_T2 && phase_en && !q_ff.ready_s2 |=>
      bus.wait_o;
  endproperty
  a_wait: assert property (p_wait)
    else $error("wait not entered");

  property p_release;
    @(posedge clk) disable iff (!arst_n)
    !bus.cycle_sync && bus.data_oe |-> is_write(q_ff.cur.kind);
  endproperty
  a_release: assert property (p_release)
    else $error("data bus driven outside status or write");

  property p_hold;
    @(posedge clk) disable iff (!arst_n)
    bus.hold_ack |-> !bus.addr_oe && !bus.data_oe;
  endproperty
  a_hold: assert property (p_hold)
    else $error("bus driven in hold");

  property p_fetch_bit;
    @(posedge clk) disable iff (!arst_n)
    bus.cycle_sync |-> bus.data_o[mcs_pkg::OPCODE_FETCH_BIT] ==
      (q_ff.cur.kind inside {mcs_pkg::CYC_FETCH, mcs_pkg::CYC_IRQ_ACK,
       mcs_pkg::CYC_HALT_IRQ_ACK});
  endproperty
  a_fetch_bit: assert property (p_fetch_bit)
    else $error("opcode fetch bit wrong");

  property p_stack_bit;
    @(posedge clk) disable iff (!arst_n)
    bus.cycle_sync |-> bus.data_o[mcs_pkg::STACK_BIT] ==
      (q_ff.cur.kind inside {mcs_pkg::CYC_STACK_RD, mcs_pkg::CYC_STACK_WR});
  endproperty
  a_stack_bit: assert property (p_stack_bit)
    else $error("stack bit wrong");

  property p_mem_read_bit;
    @(posedge clk) disable iff (!arst_n)
    bus.cycle_sync |-> bus.data_o[mcs_pkg::MEM_READ_BIT] ==
      (q_ff.cur.kind inside {mcs_pkg::CYC_FETCH, mcs_pkg::CYC_MEM_RD,
       mcs_pkg::CYC_STACK_RD, mcs_pkg::CYC_HALT_ACK});
  endproperty
  a_mem_read_bit: assert property (p_mem_read_bit)
    else $error("memory read bit wrong");

  property p_port_bits;
    @(posedge clk) disable iff (!arst_n)
    bus.cycle_sync |-> (bus.data_o[mcs_pkg::PORT_OUT_BIT] ==
      (q_ff.cur.kind == mcs_pkg::CYC_PORT_OUT)) &&
      (bus.data_o[mcs_pkg::PORT_INPUT_BIT] ==
      (q_ff.cur.kind == mcs_pkg::CYC_PORT_IN));
  endproperty
  a_port_bits: assert property (p_port_bits)
    else $error("port direction bits wrong");

  property p_wait_exit;
    @(posedge clk) disable iff (!arst_n)
    bus.wait_o && phase_en && q_ff.ready_s2 |=> !bus.wait_o &&
      bus.addr_oe;
  endproperty
  a_wait_exit: assert property (p_wait_exit)
    else $error("wait not left when ready");

  property p_no_t4;
    @(posedge clk) disable iff (!arst_n)
    q_ff.st == mcs_pkg::ST_T3 && phase_en && !q_ff.cur.need_t4 |=>
      q_ff.st != mcs_pkg::ST_T4;
  endproperty
  a_no_t4: assert property (p_no_t4)
    else $error("extra state entered without need");

  c_fetch: cover property (@(posedge clk) disable iff (!arst_n)
    bus.cycle_sync && bus.data_o == mcs_pkg::ST_FETCH);
  c_wait: cover property (@(posedge clk) disable iff (!arst_n)
    bus.wait_o);
  c_hold: cover property (@(posedge clk) disable iff (!arst_n)
    bus.hold_ack);
  c_port_out: cover property (@(posedge clk) disable iff (!arst_n)
    bus.cycle_sync && bus.data_o == mcs_pkg::ST_PORT_OUT);
  c_ext: cover property (@(posedge clk) disable iff (!arst_n)
    q_ff.st == mcs_pkg::ST_T5);

endmodule

// File: dv/status_latch_model.sv
// Partner: status latch, ready stall and read data source
`timescale 1ns/1ps
module status_latch_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire mcs_pkg::bus_out_s bus,
  input wire logic [3:0] stall,
  input wire logic [7:0] rd_val,
  output logic ready_in,
  output logic [7:0] data_i,
  output logic [7:0] latched
);
  logic [3:0] cnt_ff;
  logic [7:0] last_ff;
  logic en_ff;
  // Latch status on strobe, count stall states
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latched <= 8'h00;
      cnt_ff <= 4'h0;
      last_ff <= 8'h00;
      en_ff <= 1'b0;
    end else begin
      if (bus.cycle_sync) latched <= bus.data_o;
      if (bus.cycle_sync) cnt_ff <= stall;
      else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
      last_ff <= data_i;
      en_ff <= bus.data_in_en;
    end
  end
  // Ready low while stalling; the device sees ready two clocks late,
  // so a stalling memory also holds it low in idle and in T1
  assign ready_in = (cnt_ff == 4'h0) &&
    !(stall != 4'h0 && (!bus.addr_oe || bus.cycle_sync));
  // Data while turned inward and one clock after, else a moving pattern
  assign data_i = (bus.data_in_en || en_ff) ? rd_val : ~last_ff;
endmodule

// File: dv/machine_cycle_status_word_bench.sv
// Self-checking bench for the machine cycle status sequencer
`timescale 1ns/1ps
module machine_cycle_status_word_bench;
  typedef struct packed {
    mcs_pkg::cycle_e kind;
    logic [7:0] st;
  } row_s;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic hold_req = 1'b0;
  logic [3:0] stall = 4'h0;
  logic [7:0] rd_val = 8'h5a;
  mcs_pkg::cycle_req_s req = '0;
  logic req_ready, ready_in, rd_valid;
  logic [7:0] data_i, rd_data, latched;
  mcs_pkg::bus_out_s bus;
  int bad_count = 0;
  int check_count = 0;
  int syncs, waits;
  int gap;
  logic wr_seen;
  logic [15:0] a_seen;
  row_s rows [10];
  // Clock
  always #4 clk = ~clk;
  machine_cycle_status_word dut (
    .clk(clk), .arst_n(arst_n), .phase_en(1'b1), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .ready_in(ready_in),
    .hold_req(hold_req), .data_i(data_i), .bus(bus),
    .rd_data(rd_data), .rd_valid(rd_valid));
  status_latch_model partner (
    .clk(clk), .arst_n(arst_n), .bus(bus), .stall(stall),
    .rd_val(rd_val), .ready_in(ready_in), .data_i(data_i),
    .latched(latched));
  // Compare and report
  task chk(string nm, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", nm, e, g);
      bad_count++;
    end
  endtask
  task stop_test;
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One machine cycle, watched state by state
  task run(mcs_pkg::cycle_e k, logic [7:0] st);
    logic [15:0] a;
    a = 16'hab35;
    @(posedge clk);
    req <= '{k, a, 8'hc6, 1'b0, 1'b0};
    req_valid <= 1'b1;
    rd_val <= rd_val + 8'h11;
    for (int i = 0; i < 30; i++) begin
      @(negedge clk);
      if (req_ready === 1'b1) break;
    end
    @(posedge clk);
    req_valid <= 1'b0;
    syncs = 0;
    waits = 0;
    wr_seen = 1'b0;
    for (int i = 0; i < 12 + stall; i++) begin
      @(negedge clk);
      if (bus.cycle_sync === 1'b1) begin
        syncs++;
        a_seen = bus.addr;
      end
      if (bus.wait_o === 1'b1) waits++;
      if (bus.write_n === 1'b0) wr_seen = 1'b1;
      if (bus.data_oe === 1'b1 && bus.cycle_sync !== 1'b1)
        chk("drive", st[1] ? 16'hffff : 16'h00c6, 16'(bus.data_o));
      if (rd_valid === 1'b1)
        chk("rd_data", 16'(rd_val), 16'(rd_data));
    end
    chk("sync", 16'h1, 16'(syncs));
    chk("status", 16'(st), 16'(latched));
    chk("write", 16'(!st[1]), 16'(wr_seen));
    chk("addr", (st[4] | st[6]) ? 16'h3535 : a, a_seen);
    chk("wait", 16'(stall != 4'h0), 16'(waits != 0));
  endtask
  // Main sequence
  initial begin
    rows = '{'{mcs_pkg::CYC_FETCH, 8'ha2}, '{mcs_pkg::CYC_MEM_RD, 8'h82},
      '{mcs_pkg::CYC_STACK_RD, 8'h86}, '{mcs_pkg::CYC_PORT_IN, 8'h42},
      '{mcs_pkg::CYC_IRQ_ACK, 8'h23}, '{mcs_pkg::CYC_HALT_ACK, 8'h8a},
      '{mcs_pkg::CYC_HALT_IRQ_ACK, 8'h2b}, '{mcs_pkg::CYC_MEM_WR, 8'h00},
      '{mcs_pkg::CYC_STACK_WR, 8'h04}, '{mcs_pkg::CYC_PORT_OUT, 8'h10}};
    repeat (15) @(posedge clk);
    @(negedge clk);
    chk("rst", 16'h1, 16'({bus.addr_oe, bus.data_oe, bus.cycle_sync,
      bus.write_n}));
    @(posedge clk);
    arst_n <= 1'b1;
    foreach (rows[i]) run(rows[i].kind, rows[i].st);
    // Back-to-back fetches with both extra states: six states apart
    @(posedge clk);
    req <= '{mcs_pkg::CYC_FETCH, 16'h1234, 8'h00, 1'b1, 1'b1};
    req_valid <= 1'b1;
    syncs = 0;
    gap = 0;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if (syncs == 1) gap++;
      if (bus.cycle_sync === 1'b1) syncs++;
      if (syncs == 2) break;
    end
    @(posedge clk);
    req_valid <= 1'b0;
    chk("extra_states", 16'h6, 16'(gap));
    @(posedge clk);
    stall <= 4'h6;
    run(mcs_pkg::CYC_MEM_RD, 8'h82);
    run(mcs_pkg::CYC_MEM_WR, 8'h00);
    @(posedge clk);
    stall <= 4'h0;
    hold_req <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if (bus.hold_ack === 1'b1) break;
    end
    chk("hold", 16'h2, 16'({bus.hold_ack, bus.data_oe}));
    @(posedge clk);
    hold_req <= 1'b0;
    run(mcs_pkg::CYC_PORT_OUT, 8'h10);
    stop_test();
  end
  // Watchdog
  initial begin
    #100000;
    bad_count++;
    stop_test();
  end
endmodule
